/* File: jtdp_defs.vh */
/*
 * Constants of the test access port debug block: state codes,
 * instruction codes, capture values and fixed widths.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef JTDP_DEFS_VH
`define JTDP_DEFS_VH

// ****************************************************************
// controller state codes
// ****************************************************************
`define JTDP_ST_RESET      4'hF
`define JTDP_ST_IDLE       4'hC
`define JTDP_ST_SEL_DR     4'h7
`define JTDP_ST_CAP_DR     4'h6
`define JTDP_ST_SH_DR      4'h2
`define JTDP_ST_EX1_DR     4'h1
`define JTDP_ST_PAU_DR     4'h3
`define JTDP_ST_EX2_DR     4'h0
`define JTDP_ST_UPD_DR     4'h5
`define JTDP_ST_SEL_IR     4'h4
`define JTDP_ST_CAP_IR     4'hE
`define JTDP_ST_SH_IR      4'hA
`define JTDP_ST_EX1_IR     4'h9
`define JTDP_ST_PAU_IR     4'hB
`define JTDP_ST_EX2_IR     4'h8
`define JTDP_ST_UPD_IR     4'hD

// ****************************************************************
// instruction register
// ****************************************************************
`define JTDP_IR_W          4
`define JTDP_IR_CAPTURE    4'h1
`define JTDP_IR_RESET_VAL  4'hF
`define JTDP_OP_DBG_A      4'h8
`define JTDP_OP_DBG_B      4'h9
`define JTDP_OP_DBG_C      4'hA
`define JTDP_OP_DBG_D      4'hB

// ****************************************************************
// data register widths
// ****************************************************************
`define JTDP_BRK_W         16
`define JTDP_SCAN_W        16
`define JTDP_CMD_W         8

`endif

/* File: jtdp_fsm.v */
/*
 * Sixteen-state test port controller, advanced by a one-cycle
 * rising test clock enable. Assumes tms is already synchronised.
 */
`timescale 1ns/10ps
`include "jtdp_defs.vh"

module jtdp_fsm (
    // clock and reset
    input  wire       clk_i,
    input  wire       srst_i,
    // control
    input  wire       hold_rst_i,
    input  wire       tck_rise_i,
    input  wire       tms_i,
    // state
    output wire [3:0] state_o
);

    reg [3:0] state_q;
    reg [3:0] state_d;

    assign state_o = state_q;

    // ****************************************************************
    // next state
    // ****************************************************************
    always @* begin
        case (state_q)
            `JTDP_ST_RESET:  state_d = tms_i ? `JTDP_ST_RESET
                                             : `JTDP_ST_IDLE;
            `JTDP_ST_IDLE:   state_d = tms_i ? `JTDP_ST_SEL_DR
                                             : `JTDP_ST_IDLE;
            `JTDP_ST_SEL_DR: state_d = tms_i ? `JTDP_ST_SEL_IR
                                             : `JTDP_ST_CAP_DR;
            `JTDP_ST_CAP_DR: state_d = tms_i ? `JTDP_ST_EX1_DR
                                             : `JTDP_ST_SH_DR;
            `JTDP_ST_SH_DR:  state_d = tms_i ? `JTDP_ST_EX1_DR
                                             : `JTDP_ST_SH_DR;
            `JTDP_ST_EX1_DR: state_d = tms_i ? `JTDP_ST_UPD_DR
                                             : `JTDP_ST_PAU_DR;
            `JTDP_ST_PAU_DR: state_d = tms_i ? `JTDP_ST_EX2_DR
                                             : `JTDP_ST_PAU_DR;
            `JTDP_ST_EX2_DR: state_d = tms_i ? `JTDP_ST_UPD_DR
                                             : `JTDP_ST_SH_DR;
            `JTDP_ST_UPD_DR: state_d = tms_i ? `JTDP_ST_SEL_DR
                                             : `JTDP_ST_IDLE;
            `JTDP_ST_SEL_IR: state_d = tms_i ? `JTDP_ST_RESET
                                             : `JTDP_ST_CAP_IR;
            `JTDP_ST_CAP_IR: state_d = tms_i ? `JTDP_ST_EX1_IR
                                             : `JTDP_ST_SH_IR;
            `JTDP_ST_SH_IR:  state_d = tms_i ? `JTDP_ST_EX1_IR
                                             : `JTDP_ST_SH_IR;
            `JTDP_ST_EX1_IR: state_d = tms_i ? `JTDP_ST_UPD_IR
                                             : `JTDP_ST_PAU_IR;
            `JTDP_ST_PAU_IR: state_d = tms_i ? `JTDP_ST_EX2_IR
                                             : `JTDP_ST_PAU_IR;
            `JTDP_ST_EX2_IR: state_d = tms_i ? `JTDP_ST_UPD_IR
                                             : `JTDP_ST_SH_IR;
            `JTDP_ST_UPD_IR: state_d = tms_i ? `JTDP_ST_SEL_DR
                                             : `JTDP_ST_IDLE;
            default:         state_d = `JTDP_ST_RESET;
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // no async test reset pin; only chip reset, the port hold or tms
    always @(posedge clk_i) begin
        if (srst_i || hold_rst_i) begin
            state_q <= `JTDP_ST_RESET;
        end else if (tck_rise_i) begin
            state_q <= state_d;
        end
    end

endmodule // jtdp_fsm

/* File: jtdp_sync.v */
/*
 * Two-flop synchroniser for the test pins, with a rising edge
 * pulse for the test clock. Assumes pins are asynchronous to clk_i.
 */
`timescale 1ns/10ps

module jtdp_sync #(
    parameter W = 3
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         srst_i,
    // pins
    input  wire [W-1:0] async_i,
    // synchronised
    output wire [W-1:0] sync_o,
    output wire         rise0_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    reg         last_q;

    assign sync_o  = sync_q;
    // edge taken from second stage only
    assign rise0_o = sync_q[0] & ~last_q;

    always @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
            last_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            last_q <= sync_q[0];
        end
    end

endmodule // jtdp_sync

/* File: jtdp_top.v */
/*
 * Test access port with debug access: controller, four-bit
 * instruction register, data register selection, break unit
 * configuration and debug scan chain.
 * Assumes the test pins are asynchronous and that the test clock
 * is much slower than clk_i (at least four clk_i per half period).
 */
// Overview of operation
// - everything but the serial output advances on sampled test clock rises
// - no asynchronous test reset input exists
// - fuse unprogrammed: pins normal, controller held reset
// - serial output driven only while shifting
// - sixteen states, reset state after power-on
// - least significant bit shifts first
// - four bit instruction, last bit on exit
// - instruction capture shifts out 0x01
// - instruction output changes only in update-ir or test-logic-reset
// - instruction selects data register and its logic
// - shift out values captured in capture-dr
// - latched outputs change only in update-dr or test-logic-reset
// - exit and pause states do nothing
// - five tms highs always reach reset
// - break on flow change, step, four points
// - debug needs both fuses, no lock bits
// - debug injects cpu instructions, reads result byte
`timescale 1ns/10ps
`include "jtdp_defs.vh"

module jtdp_top (
    // clock and reset
    input  wire                    clk_i,
    input  wire                    srst_i,
    // test pins
    input  wire                    tck_i,
    input  wire                    tms_i,
    input  wire                    tdi_i,
    output wire                    tdo_o,
    output wire                    tdo_oe_o,
    // fuses and control bits
    input  wire                    test_port_enable_fuse_i,
    input  wire                    test_port_disable_bit_i,
    input  wire                    debug_enable_fuse_i,
    input  wire                    lock_bit_one_i,
    input  wire                    lock_bit_two_i,
    // status
    output wire                    port_active_o,
    output wire                    debug_active_o,
    output wire [3:0]              tap_state_o,
    output wire [`JTDP_IR_W-1:0]   instr_o,
    // processor side of the debug scan chain
    input  wire [`JTDP_CMD_W-1:0]  cpu_result_i,
    input  wire                    cpu_result_dirty_i,
    output wire [`JTDP_SCAN_W-1:0] cpu_inject_o,
    output wire                    cpu_inject_vld_o,
    output wire                    result_taken_o,
    // break unit configuration
    output wire                    brk_flow_o,
    output wire                    brk_step_o,
    output wire [1:0]              brk_mode_o,
    output wire [`JTDP_BRK_W-1:0]  brk_pm0_o,
    output wire [`JTDP_BRK_W-1:0]  brk_pm1_o,
    output wire [`JTDP_BRK_W-1:0]  brk_cmb0_o,
    output wire [`JTDP_BRK_W-1:0]  brk_cmb1_o
);

    // ****************************************************************
    // pin synchronisation and enables
    // ****************************************************************
    wire [2:0] pins_s;
    wire       tck_rise;
    wire       tck_s;
    wire       tms_s;
    wire       tdi_s;
    reg        tck_last_q;
    wire       tck_fall;

    // tms and tdi take the same two stages as tck, so both
    // already stand when the rise pulse samples them
    jtdp_sync #(
        .W (3)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i ({tdi_i, tms_i, tck_i}),
        .sync_o  (pins_s),
        .rise0_o (tck_rise)
    );

    assign tck_s = pins_s[0];
    assign tms_s = pins_s[1];
    assign tdi_s = pins_s[2];

    always @(posedge clk_i) begin
        if (srst_i) begin
            tck_last_q <= 1'b0;
        end else begin
            tck_last_q <= tck_s;
        end
    end

    // fall detector kept here; the sync module reports rises only
    assign tck_fall = ~tck_s & tck_last_q;

    wire port_en = test_port_enable_fuse_i & ~test_port_disable_bit_i;
    wire dbg_en  = port_en & debug_enable_fuse_i
                   & ~lock_bit_one_i & ~lock_bit_two_i;

    assign port_active_o  = port_en;
    assign debug_active_o = dbg_en;

    // ****************************************************************
    // controller
    // ****************************************************************
    wire [3:0] st;

    // tms is the only steering input; held reset while disabled
    jtdp_fsm u_fsm (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .hold_rst_i (~port_en),
        .tck_rise_i (tck_rise),
        .tms_i      (tms_s),
        .state_o    (st)
    );

    assign tap_state_o = st;

    wire in_sh_ir  = (st == `JTDP_ST_SH_IR);
    wire in_sh_dr  = (st == `JTDP_ST_SH_DR);
    wire do_cap_ir = tck_rise & (st == `JTDP_ST_CAP_IR);
    wire do_cap_dr = tck_rise & (st == `JTDP_ST_CAP_DR);
    wire do_sh_ir  = tck_rise & in_sh_ir;
    wire do_sh_dr  = tck_rise & in_sh_dr;
    wire do_upd_ir = tck_rise & (st == `JTDP_ST_UPD_IR);
    wire do_upd_dr = tck_rise & (st == `JTDP_ST_UPD_DR);
    wire in_rst    = (st == `JTDP_ST_RESET);

    // ****************************************************************
    // instruction register
    // ****************************************************************
    reg [`JTDP_IR_W-1:0] ir_sh_q;
    reg [`JTDP_IR_W-1:0] ir_q;
    // test-logic-reset reloads the capture value and the bypass code

    always @(posedge clk_i) begin
        if (srst_i || in_rst) begin
            ir_sh_q <= `JTDP_IR_CAPTURE;
            ir_q    <= `JTDP_IR_RESET_VAL;
        end else begin
            if (do_cap_ir) begin
                ir_sh_q <= `JTDP_IR_CAPTURE;
            end else if (do_sh_ir) begin
                ir_sh_q <= {tdi_s, ir_sh_q[`JTDP_IR_W-1:1]};
            end
            if (do_upd_ir) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    assign instr_o = ir_q;

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    // debug ops fall to bypass when debug is locked out
    wire op_a = dbg_en & (ir_q == `JTDP_OP_DBG_A);
    wire op_b = dbg_en & (ir_q == `JTDP_OP_DBG_B);
    wire op_c = dbg_en & (ir_q == `JTDP_OP_DBG_C);
    wire op_d = dbg_en & (ir_q == `JTDP_OP_DBG_D);
    // no further decode: every other code is plain bypass

    // ****************************************************************
    // data registers
    // ****************************************************************
    // op_a: break control, op_b: break point address with index,
    // op_c: cpu instruction injection, op_d: result readback
    reg                    byp_q;
    reg [`JTDP_BRK_W+5:0]  brk_sh_q;
    reg [`JTDP_SCAN_W-1:0] scan_sh_q;
    reg [`JTDP_CMD_W:0]    res_sh_q;
    reg [3:0]              ctl_q;
    reg [`JTDP_BRK_W-1:0]  bp_q [0:3];
    reg [`JTDP_SCAN_W-1:0] inj_q;
    reg                    inj_vld_q;
    reg                    taken_q;
    integer                k;

    always @(posedge clk_i) begin
        if (srst_i || in_rst) begin
            byp_q     <= 1'b0;
            brk_sh_q  <= {(`JTDP_BRK_W+6){1'b0}};
            scan_sh_q <= {`JTDP_SCAN_W{1'b0}};
            res_sh_q  <= {(`JTDP_CMD_W+1){1'b0}};
            ctl_q     <= 4'h0;
            inj_q     <= {`JTDP_SCAN_W{1'b0}};
            inj_vld_q <= 1'b0;
            taken_q   <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                bp_q[k] <= {`JTDP_BRK_W{1'b0}};
            end
        end else begin
            inj_vld_q <= 1'b0;
            taken_q   <= 1'b0;
            // bypass stage starts at 0, so its first bit out is 0
            if (do_cap_dr) begin
                byp_q     <= 1'b0;
                brk_sh_q  <= {2'b00, ctl_q, bp_q[0]};
                scan_sh_q <= inj_q;
                res_sh_q  <= {cpu_result_dirty_i, cpu_result_i};
            end else if (do_sh_dr) begin
                byp_q <= tdi_s;
                if (op_a || op_b) begin
                    brk_sh_q <= {tdi_s, brk_sh_q[`JTDP_BRK_W+5:1]};
                end
                if (op_c) begin
                    scan_sh_q <= {tdi_s, scan_sh_q[`JTDP_SCAN_W-1:1]};
                end
                if (op_d) begin
                    res_sh_q <= {tdi_s, res_sh_q[`JTDP_CMD_W:1]};
                end
            end
            if (do_upd_dr) begin
                if (op_a) begin
                    ctl_q <= brk_sh_q[`JTDP_BRK_W+3:`JTDP_BRK_W];
                end
                if (op_b) begin
                    bp_q[brk_sh_q[`JTDP_BRK_W+1:`JTDP_BRK_W]]
                        <= brk_sh_q[`JTDP_BRK_W-1:0];
                end
                if (op_c) begin
                    inj_q     <= scan_sh_q;
                    inj_vld_q <= 1'b1;
                end
                if (op_d) begin
                    taken_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // serial output
    // ****************************************************************
    // changes on the falling test clock so the far end samples
    // a stable bit on the next rise; exit/pause states touch nothing
    reg tdo_q;
    reg tdo_oe_q;
    reg tdo_d;

    always @* begin
        if (in_sh_ir) begin
            tdo_d = ir_sh_q[0];
        end else if (op_a || op_b) begin
            tdo_d = brk_sh_q[0];
        end else if (op_c) begin
            tdo_d = scan_sh_q[0];
        end else if (op_d) begin
            tdo_d = res_sh_q[0];
        end else begin
            tdo_d = byp_q;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i || !port_en) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= in_sh_ir | in_sh_dr;
        end
    end

    assign tdo_o    = tdo_q;
    // port_en gate drops the enable at once when the port fuse or disable bit turns the port off
    assign tdo_oe_o = tdo_oe_q & port_en;

    // ****************************************************************
    // outputs to processor and break unit
    // ****************************************************************
    assign cpu_inject_o     = inj_q;
    assign cpu_inject_vld_o = inj_vld_q;
    assign result_taken_o   = taken_q;
    assign brk_flow_o       = ctl_q[0];
    assign brk_step_o       = ctl_q[1];
    assign brk_mode_o       = ctl_q[3:2];
    // slots 0 and 1 are program points, 2 and 3 the combined ones
    assign brk_pm0_o        = bp_q[0];
    assign brk_pm1_o        = bp_q[1];
    assign brk_cmb0_o       = bp_q[2];
    assign brk_cmb1_o       = bp_q[3];

endmodule // jtdp_top

/* File: jtdp_top_props.sv */
/* Checker for the test port block: port gating, output enable,
   update moments and debug pulses.
   Assumes binding into jtdp_top and that jtdp_defs.vh is reachable. */
`timescale 1ns/10ps
`include "jtdp_defs.vh"

module jtdp_top_props (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        srst_i,
    // pins and fuses
    input wire logic        tdo_oe_o,
    input wire logic        test_port_enable_fuse_i,
    input wire logic        test_port_disable_bit_i,
    input wire logic        debug_enable_fuse_i,
    input wire logic        lock_bit_one_i,
    input wire logic        lock_bit_two_i,
    // status and outputs
    input wire logic        port_active_o,
    input wire logic        debug_active_o,
    input wire logic [3:0]  tap_state_o,
    input wire logic [3:0]  instr_o,
    input wire logic        cpu_inject_vld_o,
    input wire logic        result_taken_o,
    input wire logic        brk_flow_o,
    input wire logic        brk_step_o,
    input wire logic [1:0]  brk_mode_o,
    input wire logic [15:0] brk_pm0_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_reset_values: assert property (@(posedge clk_i) disable iff (1'b0)
        srst_i |=> tap_state_o == `JTDP_ST_RESET && !tdo_oe_o
            && instr_o == `JTDP_IR_RESET_VAL && !cpu_inject_vld_o)
        else $error("reset values wrong");
    chk_port_enable: assert property (
        port_active_o == (test_port_enable_fuse_i && !test_port_disable_bit_i))
        else $error("port enable mismatch");
    chk_port_held: assert property (
        !port_active_o |=> tap_state_o == `JTDP_ST_RESET && !tdo_oe_o)
        else $error("disabled port not held in reset");
    chk_debug_gate: assert property (
        debug_active_o == (port_active_o && debug_enable_fuse_i
            && !lock_bit_one_i && !lock_bit_two_i))
        else $error("debug gate mismatch");
    chk_oe_shift: assert property (
        $rose(tdo_oe_o) |-> tap_state_o == `JTDP_ST_SH_IR
            || tap_state_o == `JTDP_ST_SH_DR)
        else $error("output driven outside shift");
    chk_oe_reset: assert property (
        tap_state_o == `JTDP_ST_RESET |-> !tdo_oe_o)
        else $error("output driven in reset state");
    chk_instr_update: assert property ($changed(instr_o) |->
        $past(tap_state_o) inside {`JTDP_ST_UPD_IR, `JTDP_ST_RESET}
        || tap_state_o inside {`JTDP_ST_UPD_IR, `JTDP_ST_RESET})
        else $error("instruction changed outside update");
    chk_brk_update: assert property (
        $changed({brk_flow_o, brk_step_o, brk_mode_o, brk_pm0_o}) |->
        $past(tap_state_o) inside {`JTDP_ST_UPD_DR, `JTDP_ST_RESET}
        || tap_state_o inside {`JTDP_ST_UPD_DR, `JTDP_ST_RESET})
        else $error("break setting changed outside update");
    chk_inject_pulse: assert property (cpu_inject_vld_o |->
        (instr_o == `JTDP_OP_DBG_C && debug_active_o) ##1 !cpu_inject_vld_o)
        else $error("inject pulse wrong");
    chk_taken_pulse: assert property (result_taken_o |->
        (instr_o == `JTDP_OP_DBG_D && debug_active_o) ##1 !result_taken_o)
        else $error("result taken pulse wrong");
    // tck high lasts at least four clocks, so no state lasts fewer
    chk_state_hold: assert property ($changed(tap_state_o)
        && port_active_o && $past(port_active_o) |=> $stable(tap_state_o)[*3])
        else $error("state changed too soon");
    chk_select_ir: assert property ($changed(tap_state_o) && port_active_o
        && $past(tap_state_o) == `JTDP_ST_SEL_IR
        |-> tap_state_o inside {`JTDP_ST_CAP_IR, `JTDP_ST_RESET})
        else $error("bad branch from select-ir");

    // ****************************************************************
    // cover
    // ****************************************************************
    cov_inject: cover property (cpu_inject_vld_o);
    cov_taken:  cover property (result_taken_o);
    cov_oe_ir:  cover property ($rose(tdo_oe_o)
        && tap_state_o == `JTDP_ST_SH_IR);
endmodule // jtdp_top_props

/* File: jtdp_ctrl_model.sv */
/* Model of the external test controller: drives tck, tms, tdi and
   reads tdo. Assumes a pull-up on tdo; tck stands low between frames. */
`timescale 1ns/10ps

module jtdp_ctrl_model (
    // test pins
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    wire line;

    // released output floats up to the pull-up level
    assign line = tdo_oe_i ? tdo_i : 1'b1;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // ****************************************************************
    // one test clock of 320 ns; tdo read just after the rise
    // ****************************************************************
    task automatic pulse(input logic m, input logic d, output logic q);
        #40;
        tms_o = m;
        tdi_o = d;
        #120;
        tck_o = 1'b1;
        #20;
        q = line;
        #140;
        tck_o = 1'b0;
    endtask

    task automatic tms_seq(input int n, input logic m);
        logic q;
        repeat (n) pulse(m, 1'b0, q);
    endtask

    // ****************************************************************
    // full scan from idle back to idle
    // ****************************************************************
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        int   i;
        dout = '0;
        pulse(1'b1, 1'b0, q);
        if (ir)
            pulse(1'b1, 1'b0, q);
        tms_seq(2, 1'b0);
        for (i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, 1'b0, q);
        pulse(1'b0, 1'b0, q);
    endtask
endmodule // jtdp_ctrl_model

/* File: jtdp_top_tb.sv */
/* Self-checking bench for jtdp_top with a controller model.
   Assumes jtdp_defs.vh on the include path; expectations from rules. */
`timescale 1ns/10ps
`include "jtdp_defs.vh"

module jtdp_top_tb;
    logic        clk_i, srst_i, fuse, dis, dbg, lk1, lk2, dirty;
    logic [7:0]  res;
    wire         tck, tms, tdi, tdo, tdo_oe, p_act, d_act, inj_v, taken;
    wire         flow, step;
    wire [1:0]   mode;
    wire [3:0]   state, instr;
    wire [15:0]  inj, pm0, pm1, cmb0, cmb1;
    integer      fails, compares, seed, n_inj, n_tak, k;
    logic [31:0] d, e, dout;
    logic [15:0] bp [4];
    logic [4:0]  op;

    jtdp_top u_jtdp_top (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .test_port_enable_fuse_i(fuse), .test_port_disable_bit_i(dis),
        .debug_enable_fuse_i(dbg), .lock_bit_one_i(lk1),
        .lock_bit_two_i(lk2), .port_active_o(p_act),
        .debug_active_o(d_act), .tap_state_o(state), .instr_o(instr),
        .cpu_result_i(res), .cpu_result_dirty_i(dirty),
        .cpu_inject_o(inj), .cpu_inject_vld_o(inj_v),
        .result_taken_o(taken), .brk_flow_o(flow), .brk_step_o(step),
        .brk_mode_o(mode), .brk_pm0_o(pm0), .brk_pm1_o(pm1),
        .brk_cmb0_o(cmb0), .brk_cmb1_o(cmb1));
    jtdp_ctrl_model u_jtdp_ctrl_model (.tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (inj_v === 1'b1) n_inj <= n_inj + 1;
        if (taken === 1'b1) n_tak <= n_tak + 1;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic ir(input logic [3:0] v);
        @(negedge clk_i);
        u_jtdp_ctrl_model.scan(1'b1, 4, {28'h0, v}, dout);
        check(dout, `JTDP_IR_CAPTURE);
        check(instr, v);
    endtask
    task automatic dr(input int n, input logic [31:0] v);
        @(negedge clk_i);
        u_jtdp_ctrl_model.scan(1'b0, n, v, dout);
    endtask
    function automatic logic [31:0] bypass(input logic [31:0] v, input int n);
        return (v << 1) & ((32'h1 << n) - 32'h1);
    endfunction
    task test_done;
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #2000000;
        fails = fails + 1;
        test_done;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 59878;
        {fails, compares, n_inj, n_tak} = '0;
        {srst_i, fuse, dis, dbg, lk1, lk2, dirty, res} = {7'b1101000, 8'h00};
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        check(state, `JTDP_ST_RESET);
        check(instr, `JTDP_IR_RESET_VAL);
        u_jtdp_ctrl_model.tms_seq(1, 1'b0);
        for (op = 0; op < 16; op++) begin
            if (op[3:2] != 2'b10) begin
                ir(op[3:0]);
                d = $random(seed);
                dr(8, d);
                check(dout, bypass(d, 8));
                check(tdo_oe, 1'b0);
            end
        end
        ir(`JTDP_OP_DBG_A);
        d = $random(seed);
        dr(22, d);
        check({mode, step, flow}, d[19:16]);
        ir(`JTDP_OP_DBG_B);
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            d[17:16] = k[1:0];
            bp[k] = d[15:0];
            dr(22, d);
        end
        check({pm0, pm1}, {bp[0], bp[1]});
        check({cmb0, cmb1}, {bp[2], bp[3]});
        ir(`JTDP_OP_DBG_C);
        e = $random(seed);
        dr(16, e);
        check(inj, e[15:0]);
        check(n_inj, 1);
        d = $random(seed);
        dr(16, d);
        check(dout, e[15:0]);
        check(n_inj, 2);
        @(negedge clk_i);
        res = $random(seed);
        dirty = 1'b1;
        ir(`JTDP_OP_DBG_D);
        dr(9, $random(seed));
        check(dout, {dirty, res});
        check(n_tak, 1);
        // each gate alone turns the injection code JTDP_OP_DBG_C into bypass
        for (k = 0; k < 3; k++) begin
            @(negedge clk_i);
            {lk1, lk2, dbg} = {k == 0, k == 1, k != 2};
            ir(`JTDP_OP_DBG_C);
            check(d_act, 1'b0);
            d = $random(seed);
            dr(16, d);
            check(dout, bypass(d, 16));
            check(n_inj, 2);
        end
        dbg = 1'b1;
        ir(`JTDP_OP_DBG_A);
        u_jtdp_ctrl_model.tms_seq(1, 1'b1);
        u_jtdp_ctrl_model.tms_seq(2, 1'b0);
        u_jtdp_ctrl_model.tms_seq(5, 1'b1);
        check(state, `JTDP_ST_RESET);
        check(instr, `JTDP_IR_RESET_VAL);
        for (k = 0; k < 2; k++) begin
            @(negedge clk_i);
            {fuse, dis} = {k == 0, k == 0};
            u_jtdp_ctrl_model.tms_seq(3, 1'b0);
            check({p_act, state}, {1'b0, `JTDP_ST_RESET});
        end
        {fuse, dis} = 2'b10;
        u_jtdp_ctrl_model.tms_seq(3, 1'b0);
        check(state, `JTDP_ST_IDLE);
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        check(state, `JTDP_ST_RESET);
        test_done;
    end
endmodule // jtdp_top_tb

bind jtdp_top jtdp_top_props u_jtdp_top_props (.clk_i, .srst_i, .tdo_oe_o,
    .test_port_enable_fuse_i, .test_port_disable_bit_i, .debug_enable_fuse_i,
    .lock_bit_one_i, .lock_bit_two_i, .port_active_o, .debug_active_o,
    .tap_state_o, .instr_o, .cpu_inject_vld_o, .result_taken_o, .brk_flow_o,
    .brk_step_o, .brk_mode_o, .brk_pm0_o);
